// ===== core/sdie_sysif.sv
// System interface data identifier, addressing and data error block
//
// What this block does
// R1: Any party driving a data cycle sets command bus bit 8 to one.
// R2: Identifiers are non-coherent only; bits 2:0 are reserved.
// R3: Bit 7 zero marks the final element, one means more follow.
// R4: Bit 6 zero marks read response data, one means not response.
// R5: Bit 5 zero means good data, one means error data.
// R6: Any returned element flagged as error raises a bus error.
// R7: Outgoing data with a parity error is still sent, flagged as error.
// R8: External bit 4 zero asks for checking, one suppresses it.
// R9: Processor identifiers reserve bits 4:3; external ones reserve bit 3.
// R10: The agent drives reserved bits to one; ignores ours.
// R11: A check bit error on any read response element with checking on raises a bus error.
// R12: Good-data flag errors raise the exception two cycles after receipt.
// R13: Check bit errors raise the exception three cycles after receipt.
// R14: One exception signal, no indication of its source.
// R15: A bus error during a block refill invalidates the line.
// R16: The agent still delivers the whole block after an error.
// R17: Block and word requests clear the two low address bits.
// R18: Half-words clear address bit 0; byte and tri-byte stay exact.
// R19: Mode register sits at its fixed address, read/write, word only.
// R20: Mode bits 2:1 pick single write protocol, reset 00.
// R21: Mode bit 0 picks block write rate; one adds two idle cycles.
// R22: Software writes ones to 31:20 and 19:4, zero to bit 3.
// R23: In alternate mode a read without reply in time raises bus error.
//
// Chosen here: the strobed register port.
`timescale 1ns/1ns
module sdie_sysif
	import sdie_pkg::*;
#(
	parameter logic [SDIE_TMO_W-1:0] READ_TIMEOUT = SDIE_TMO_DEFAULT
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Register port
	input wire logic [35:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// System command bus and data, two-way pins
	input wire logic [SDIE_CMD_W-1:0] system_command_bus_in,
	output logic [SDIE_CMD_W-1:0] system_command_bus_out,
	output logic system_command_bus_oe_n,
	input wire logic [31:0] sys_data_in,
	input wire logic [3:0] sys_check_in,
	output logic [31:0] sys_data_out,
	output logic sys_data_oe_n,
	// Link handshake pins
	input wire logic ext_valid_n,
	output logic proc_valid_n,
	input wire logic protocol_select_pin,
	// Outgoing data from the core
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic [31:0] tx_data,
	input wire logic tx_last,
	input wire logic tx_resp,
	input wire logic tx_block,
	input wire logic tx_parity_err,
	// Received data to the core
	output logic rx_valid,
	output logic [31:0] rx_data,
	output logic rx_last,
	output logic rx_resp,
	// Address requests from the core
	input wire logic req_valid,
	input wire logic [35:0] req_addr,
	input wire logic [2:0] req_size,
	output logic addr_valid,
	output logic [35:0] addr_out,
	// Read tracking, exceptions and mode outputs
	input wire logic read_issue,
	output logic bus_error,
	output logic line_invalid,
	output logic [1:0] write_mode
);
	// ==========================================================
	// State
	typedef struct packed {
		// Mode register fields and register read data
		logic [15:0] mid;
		logic rsv3;
		logic [1:0] wmode;
		logic rate;
		logic [31:0] rdata;

		// Pin synchronisers, two stages each
		logic [SDIE_CMD_W-1:0] cmd_s1;
		logic [SDIE_CMD_W-1:0] cmd_s2;
		logic [31:0] dat_s1;
		logic [31:0] dat_s2;
		logic [3:0] chk_s1;
		logic [3:0] chk_s2;
		logic ev_s1;
		logic ev_s2;
		logic mode_s1;
		logic mode_s2;

		// Error latency pipes and the merged exception
		logic gd_pipe;
		logic [1:0] cb_pipe;
		logic bus_err;

		// Block refill tracking
		logic blk;
		logic refill_err;
		logic [1:0] tail;
		logic line_inv;

		// Transmit side
		logic [1:0] idle_cnt;
		logic [SDIE_CMD_W-1:0] cmd_out;
		logic [31:0] data_out;
		logic drive;

		// Receive side handed to the core
		logic rx_v;
		logic [31:0] rx_d;
		logic rx_l;
		logic rx_r;

		// Address aligner
		logic addr_v;
		logic [35:0] addr;

		// Read reply timer
		logic rd_wait;
		logic [SDIE_TMO_W-1:0] tmo_cnt;
	} sdie_state_t;

	sdie_state_t st;
	sdie_state_t next_st;

	sdie_chk_if chk_bus ();

	logic rx_elem;
	logic is_resp;
	logic check_on;
	logic good_fail;
	logic check_fail;
	logic tmo_hit;
	logic accept;
	logic alt_mode;

	// ==========================================================
	// Check bit evaluation on the synchronised element
	assign chk_bus.data = st.dat_s2;
	assign chk_bus.check = st.chk_s2;

	sdie_check #(
		.LANES(4)
	) u_check (
		.chk(chk_bus.eval)
	);

	// ==========================================================
	// Receive decode
	// Only data cycles count; commands from the agent have bit 8 clear.
	assign rx_elem = st.ev_s2 & st.cmd_s2[SDIE_ID_MARK_BIT]; // R1
	assign is_resp = ~st.cmd_s2[SDIE_RESP_BIT]; // R4
	// Bits 3 and 2:0 are reserved and never looked at.
	assign check_on = ~st.cmd_s2[SDIE_NOCHK_BIT]; // R8
	// Error latency counts from the second flop, not from the pins
	assign good_fail = rx_elem & is_resp & st.cmd_s2[SDIE_ERR_BIT]; // R5
	assign check_fail = rx_elem & is_resp & check_on & chk_bus.mismatch;
	// Pin low selects the alternate protocol
	assign alt_mode = ~st.mode_s2;
	assign tmo_hit = st.rd_wait & (st.tmo_cnt == READ_TIMEOUT); // R23

	// Rate pacing stalls the core between block write words
	assign accept = tx_valid & tx_ready;
	assign tx_ready = (st.idle_cnt == 2'h0); // R21

	// ==========================================================
	// Address alignment
	function automatic logic [35:0] sdie_align(input logic [35:0] a,
		input logic [2:0] sz);
		logic [35:0] r;
		r = a;
		case (sz)
			SDIE_SZ_BLOCK, SDIE_SZ_WORD: r[1:0] = 2'h0; // R17
			SDIE_SZ_HALF: r[0] = 1'h0; // R18
			SDIE_SZ_BYTE, SDIE_SZ_TRI: r = a; // R18
			// Reserved sizes pass through untouched
			default: r = a;
		endcase
		return r;
	endfunction

	// ==========================================================
	// Next state
	always_comb begin
		next_st = st;

		// Pins pass two flops before any logic sees them
		next_st.cmd_s1 = system_command_bus_in;
		next_st.cmd_s2 = st.cmd_s1;
		next_st.dat_s1 = sys_data_in;
		next_st.dat_s2 = st.dat_s1;
		next_st.chk_s1 = sys_check_in;
		next_st.chk_s2 = st.chk_s1;
		next_st.ev_s1 = ~ext_valid_n;
		next_st.ev_s2 = st.ev_s1;
		next_st.mode_s1 = protocol_select_pin;
		next_st.mode_s2 = st.mode_s1;

		// Register port; only whole words exist on this port
		next_st.rdata = 32'h0000_0000;
		if (reg_wr && reg_addr == SDIE_MODE_ADDR) begin // R19
			// Top field is read-only; the rest store as written
			next_st.mid = reg_wdata[SDIE_TOP_LSB-1:SDIE_MID_LSB]; // R22
			next_st.rsv3 = reg_wdata[SDIE_RSV3_BIT]; // R22
			next_st.wmode = reg_wdata[SDIE_WMODE_LSB +: 2]; // R20
			next_st.rate = reg_wdata[SDIE_RATE_BIT]; // R21
		end
		if (reg_rd) begin
			case (reg_addr)
				SDIE_MODE_ADDR: begin
					next_st.rdata = {SDIE_TOP_READ, st.mid, st.rsv3,
						st.wmode, st.rate}; // R19
				end
				SDIE_STAT_ADDR: begin
					next_st.rdata[SDIE_ST_RDWAIT_BIT] = st.rd_wait;
					next_st.rdata[SDIE_ST_ALT_BIT] = alt_mode;
					next_st.rdata[SDIE_ST_BLK_BIT] = st.blk;
				end
				default: next_st.rdata = 32'h0000_0000;
			endcase
		end

		// Received element handed to the core
		next_st.rx_v = rx_elem;
		next_st.rx_d = st.dat_s2;
		next_st.rx_l = rx_elem & ~st.cmd_s2[SDIE_LAST_BIT]; // R3
		next_st.rx_r = rx_elem & is_resp; // R4

		// Error latency pipes; both end in the one exception
		next_st.gd_pipe = good_fail; // R6 R12
		next_st.cb_pipe = {st.cb_pipe[0], check_fail}; // R11 R13
		next_st.bus_err = st.gd_pipe | st.cb_pipe[1] | tmo_hit; // R14

		// Block refill tracking; errors of the last element still land
		// within the tail window
		if (next_st.bus_err && (st.blk || st.tail != 2'h0)) begin
			next_st.refill_err = 1'h1; // R15
		end
		next_st.line_inv = 1'h0;
		if (st.tail != 2'h0) begin
			next_st.tail = st.tail - 2'h1;
			if (st.tail == 2'h1) begin
				next_st.line_inv = st.refill_err | next_st.bus_err; // R15
				next_st.refill_err = 1'h0;
			end
		end
		if (rx_elem && is_resp) begin
			if (st.cmd_s2[SDIE_LAST_BIT]) begin
				next_st.blk = 1'h1;
			end else if (st.blk) begin
				// The agent sends the full block even after an error
				next_st.blk = 1'h0; // R16
				next_st.tail = SDIE_TAIL_LOAD;
			end
		end

		// Outgoing data cycle
		next_st.drive = accept;
		if (accept) begin
			next_st.cmd_out[SDIE_ID_MARK_BIT] = 1'h1; // R1
			next_st.cmd_out[SDIE_LAST_BIT] = ~tx_last; // R3
			next_st.cmd_out[SDIE_RESP_BIT] = ~tx_resp; // R4
			// Parity-damaged words still go out, marked bad
			next_st.cmd_out[SDIE_ERR_BIT] = tx_parity_err; // R5 R7
			next_st.cmd_out[4:0] = SDIE_ID_RSV_FILL; // R2 R9
			next_st.data_out = tx_data;
			// Single words never load the idle count; only block words are paced
			if (tx_block && st.rate) begin
				next_st.idle_cnt = SDIE_RATE_IDLE; // R21
			end
		end else if (st.idle_cnt != 2'h0) begin
			next_st.idle_cnt = st.idle_cnt - 2'h1;
		end

		// Address aligner
		next_st.addr_v = req_valid;
		if (req_valid) begin
			next_st.addr = sdie_align(req_addr, req_size);
		end

		// Read reply timer, only in the alternate protocol
		if (tmo_hit || (rx_elem && is_resp)) begin
			next_st.rd_wait = 1'h0;
			next_st.tmo_cnt = '0;
		end else if (st.rd_wait) begin
			next_st.tmo_cnt = st.tmo_cnt + 1'b1;
		end
		// A new read wins over a reply or timeout in the same cycle
		if (read_issue && alt_mode) begin
			next_st.rd_wait = 1'h1; // R23
			next_st.tmo_cnt = '0;
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st <= '0;
			st.mid <= SDIE_MID_RST;
			st.rsv3 <= SDIE_RSV3_RST;
			st.wmode <= SDIE_WMODE_RST; // R20
			st.rate <= SDIE_RATE_RST; // R21
			// Pin idles high, so start in the normal protocol
			st.mode_s1 <= 1'h1;
			st.mode_s2 <= 1'h1;
		end else begin
			st <= next_st;
		end
	end

	// ==========================================================
	// Outputs
	assign reg_rdata = st.rdata;
	assign system_command_bus_out = st.cmd_out;
	// Both buses and the valid strobe turn together
	assign system_command_bus_oe_n = ~st.drive;
	assign sys_data_out = st.data_out;
	assign sys_data_oe_n = ~st.drive;
	assign proc_valid_n = ~st.drive;
	assign rx_valid = st.rx_v;
	assign rx_data = st.rx_d;
	assign rx_last = st.rx_l;
	assign rx_resp = st.rx_r;
	assign addr_valid = st.addr_v;
	assign addr_out = st.addr;
	assign bus_error = st.bus_err; // R14
	assign line_invalid = st.line_inv;
	assign write_mode = st.wmode;
endmodule

// ===== core/sdie_pkg.sv
// Shared constants of the system interface data identifier and error block
package sdie_pkg;

	// ==========================================================
	// Register map
	localparam logic [35:0] SDIE_MODE_ADDR = 36'hF_FF10_0000;
	localparam logic [35:0] SDIE_STAT_ADDR = 36'hF_FF10_0004;

	// ==========================================================
	// Mode register fields and reset values
	localparam int SDIE_RATE_BIT = 0;
	localparam int SDIE_WMODE_LSB = 1;
	localparam int SDIE_RSV3_BIT = 3;
	localparam int SDIE_MID_LSB = 4;
	localparam int SDIE_TOP_LSB = 20;
	localparam logic SDIE_RATE_RST = 1'h0;
	localparam logic [1:0] SDIE_WMODE_RST = 2'h0;
	localparam logic SDIE_RSV3_RST = 1'h0;
	localparam logic [15:0] SDIE_MID_RST = 16'hFFFF;
	localparam logic [11:0] SDIE_TOP_READ = 12'h000;

	// Single write protocol codes
	localparam logic [1:0] SDIE_WM_LEGACY = 2'h0;
	localparam logic [1:0] SDIE_WM_RSVD = 2'h1;
	localparam logic [1:0] SDIE_WM_PIPE = 2'h2;
	localparam logic [1:0] SDIE_WM_REISSUE = 2'h3;

	// ==========================================================
	// Status register fields
	localparam int SDIE_ST_RDWAIT_BIT = 0;
	localparam int SDIE_ST_ALT_BIT = 1;
	localparam int SDIE_ST_BLK_BIT = 2;

	// ==========================================================
	// Command bus and data identifier fields
	localparam int SDIE_CMD_W = 9;
	localparam int SDIE_ID_MARK_BIT = 8;
	localparam int SDIE_LAST_BIT = 7;
	localparam int SDIE_RESP_BIT = 6;
	localparam int SDIE_ERR_BIT = 5;
	localparam int SDIE_NOCHK_BIT = 4;
	localparam logic [4:0] SDIE_ID_RSV_FILL = 5'h1F;

	// ==========================================================
	// Request sizes seen by the address aligner
	localparam logic [2:0] SDIE_SZ_BYTE = 3'h0;
	localparam logic [2:0] SDIE_SZ_HALF = 3'h1;
	localparam logic [2:0] SDIE_SZ_TRI = 3'h2;
	localparam logic [2:0] SDIE_SZ_WORD = 3'h3;
	localparam logic [2:0] SDIE_SZ_BLOCK = 3'h4;

	// ==========================================================
	// Timing counts in clock cycles
	localparam int SDIE_GOOD_ERR_LAT = 2;
	localparam int SDIE_CHK_ERR_LAT = 3;
	localparam logic [1:0] SDIE_RATE_IDLE = 2'h2;
	localparam logic [1:0] SDIE_TAIL_LOAD = 2'h3;
	localparam int SDIE_TMO_W = 16;
	localparam logic [15:0] SDIE_TMO_DEFAULT = 16'h0400;

endpackage

// ===== core/sdie_chk_if.sv
// Carrier between the receive path and the check bit evaluator
`timescale 1ns/1ns
interface sdie_chk_if;
	logic [31:0] data;
	logic [3:0] check;
	logic mismatch;

	modport eval (
		input data,
		input check,
		output mismatch
	);
	modport user (
		output data,
		output check,
		input mismatch
	);
endinterface

// ===== core/sdie_check.sv
// Check bit evaluator: one even parity bit per byte lane
`timescale 1ns/1ns
module sdie_check #(
	parameter int LANES = 4
) (
	// Element and its check bits
	sdie_chk_if.eval chk
);
	logic [LANES-1:0] lane_bad;

	// ==========================================================
	// Per-lane parity compare
	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : g_lane
			assign lane_bad[g] = ^{chk.data[8*g +: 8], chk.check[g]};
		end
	endgenerate

	assign chk.mismatch = |lane_bad;
endmodule

// ===== dv/sdie_sysif_asserts.sv
// Port level checks of the system interface identifier block
`timescale 1ns/1ns
module sdie_sysif_asserts
	import sdie_pkg::*;
#(
	parameter logic [SDIE_TMO_W-1:0] READ_TIMEOUT = SDIE_TMO_DEFAULT
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Register port
	input wire logic [35:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	// Link pins
	input wire logic [SDIE_CMD_W-1:0] system_command_bus_in,
	input wire logic [SDIE_CMD_W-1:0] system_command_bus_out,
	input wire logic system_command_bus_oe_n,
	input wire logic [31:0] sys_data_in,
	input wire logic [3:0] sys_check_in,
	input wire logic ext_valid_n,
	input wire logic proc_valid_n,
	// Core side
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire logic tx_block,
	input wire logic bus_error,
	input wire logic [1:0] write_mode
);
	logic rate;
	logic rcv;
	logic gd;
	logic bad;

	// ========
	// Helpers
	// Pacing depends on the mode word, so track the last write to it
	always_ff @(posedge clk_sys) begin
		if (rst)
			rate <= 1'h0;
		else if (reg_wr && reg_addr == SDIE_MODE_ADDR)
			rate <= reg_wdata[SDIE_RATE_BIT];
	end
	assign rcv = !ext_valid_n && system_command_bus_in[8]
		&& !system_command_bus_in[6];
	assign gd = rcv && system_command_bus_in[5];
	assign bad = rcv && !system_command_bus_in[4] && sys_check_in !=
		{^sys_data_in[31:24], ^sys_data_in[23:16], ^sys_data_in[15:8],
		^sys_data_in[7:0]};

	// ========
	// Assertions
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	a_id_mark: assert property (!system_command_bus_oe_n |->
		system_command_bus_out[8]) else $error("identifier mark low");
	a_rsv_ones: assert property (!system_command_bus_oe_n |->
		system_command_bus_out[4:0] == SDIE_ID_RSV_FILL)
		else $error("reserved bits not ones");
	a_tx_take: assert property (tx_valid && tx_ready |=>
		!proc_valid_n && !system_command_bus_oe_n)
		else $error("accepted word not driven");
	a_rate_slow: assert property (tx_valid && tx_ready && tx_block &&
		rate |=> !tx_ready [*2] ##1 tx_ready) else $error("slow pacing");
	a_rate_full: assert property (tx_valid && tx_ready && !rate |=>
		tx_ready) else $error("full rate stalled");
	a_good_lat: assert property (gd |-> ##[4:5] bus_error)
		else $error("flagged element without bus error");
	a_chk_lat: assert property (bad |-> ##[5:6] bus_error)
		else $error("check error without bus error");
	a_wmode_set: assert property (reg_wr && reg_addr == SDIE_MODE_ADDR
		|=> write_mode == $past(reg_wdata[2:1]))
		else $error("write mode not updated");
	a_unmapped: assert property (reg_rd && reg_addr != SDIE_MODE_ADDR
		&& reg_addr != SDIE_STAT_ADDR |=> reg_rdata == 32'h0)
		else $error("unmapped read not zero");
	a_rdata_once: assert property (!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data outside read cycle");
	c_good: cover property (gd);
	c_bad: cover property (bad);
	c_slow: cover property (tx_valid && tx_ready && rate);
endmodule

bind sdie_sysif sdie_sysif_asserts #(.READ_TIMEOUT(READ_TIMEOUT)) chk_u (
	.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
	.system_command_bus_in, .system_command_bus_out,
	.system_command_bus_oe_n, .sys_data_in, .sys_check_in, .ext_valid_n,
	.proc_valid_n, .tx_valid, .tx_ready, .tx_block, .bus_error,
	.write_mode);

// ===== dv/sdie_agent.sv
// External agent model returning data elements to the block
`timescale 1ns/1ns
module sdie_agent
	import sdie_pkg::*;
(
	// Clock
	input wire logic clk_sys,
	// Pins towards the block
	output logic [SDIE_CMD_W-1:0] cmd,
	output logic [31:0] data,
	output logic [3:0] check,
	output logic valid_n
);
	initial begin
		cmd = '1;
		data = '0;
		check = '0;
		valid_n = 1'h1;
	end

	// ========
	// One element per call; the caller sequences whole blocks
	task automatic send(input logic last, resp, err, nochk, bad,
		input logic [31:0] d);
		@(posedge clk_sys);
		cmd <= {1'h1, !last, !resp, err, nochk, 4'hF};
		data <= d;
		check <= {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0] ^ bad};
		valid_n <= 1'h0;
	endtask
	// Released pins invert so stale values never pass for data
	task automatic idle();
		@(posedge clk_sys);
		valid_n <= 1'h1;
		cmd <= ~cmd;
		data <= ~data;
		check <= ~check;
	endtask
endmodule

// ===== dv/sdie_sysif_bench.sv
// Self-checking bench of the system interface identifier block
`timescale 1ns/1ns
module sdie_sysif_bench
	import sdie_pkg::*;
;
	localparam logic [15:0] TMO = 16'h0008;
	logic clk_sys = 1'h0, rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
	logic [35:0] reg_addr = '0, req_addr = '0, addr_out;
	logic [31:0] reg_wdata = '0, tx_data = '0, reg_rdata, sys_data_in;
	logic [31:0] sys_data_out, rx_data;
	logic [8:0] system_command_bus_in, system_command_bus_out;
	logic [3:0] sys_check_in;
	logic [2:0] req_size = '0;
	logic [1:0] write_mode;
	logic system_command_bus_oe_n, sys_data_oe_n, ext_valid_n, proc_valid_n;
	logic protocol_select_pin = 1'h1, tx_valid = 1'h0, tx_last = 1'h0;
	logic tx_resp = 1'h0, tx_block = 1'h0, tx_parity_err = 1'h0;
	logic req_valid = 1'h0, read_issue = 1'h0;
	logic tx_ready, rx_valid, rx_last, rx_resp, addr_valid, bus_error;
	logic line_invalid;
	int miscompares = 0, compares = 0, be_cnt, li_cnt, rv_cnt, ls_cnt;
	int cyc = 0;
	logic [33:0] rx_word;

	// ========
	// Block and far side
	sdie_sysif #(.READ_TIMEOUT(TMO)) dut_u (.clk_sys, .rst, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .system_command_bus_in,
		.system_command_bus_out, .system_command_bus_oe_n, .sys_data_in,
		.sys_check_in, .sys_data_out, .sys_data_oe_n, .ext_valid_n,
		.proc_valid_n, .protocol_select_pin, .tx_valid, .tx_ready, .tx_data,
		.tx_last, .tx_resp, .tx_block, .tx_parity_err, .rx_valid, .rx_data,
		.rx_last, .rx_resp, .req_valid, .req_addr, .req_size, .addr_valid,
		.addr_out, .read_issue, .bus_error, .line_invalid, .write_mode);
	sdie_agent agent_u (.clk_sys, .cmd(system_command_bus_in),
		.data(sys_data_in), .check(sys_check_in), .valid_n(ext_valid_n));

	always #10 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		be_cnt += (bus_error === 1'h1);
		li_cnt += (line_invalid === 1'h1);
		rv_cnt += (rx_valid === 1'h1);
		ls_cnt += (rx_last === 1'h1);
		if (rx_valid === 1'h1)
			rx_word = {rx_last, rx_resp, rx_data};
		cyc++;
		if (cyc == 2000) begin
			miscompares++;
			report_and_stop();
		end
	end

	// ========
	// Shared tasks
	task automatic chk(input logic [39:0] got, exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [35:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge clk_sys);
		reg_wr <= 1'h0;
	endtask
	task automatic rd(input logic [35:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge clk_sys);
		reg_rd <= 1'h0;
		#1 d = reg_rdata;
	endtask
	// Flags are {last, resp, parity error}
	task automatic tx_chk(input logic [2:0] f, input logic [31:0] d);
		chk({proc_valid_n, system_command_bus_oe_n, sys_data_oe_n,
			system_command_bus_out},
			{3'h0, 1'h1, ~f[2:1], f[0], 5'h1F});
		chk(sys_data_out, d);
	endtask
	// Called at an edge; swaps to the second word on the accept edge
	task automatic tx_pair(input logic [2:0] f1, f2,
		input logic [31:0] d1, d2, output int n);
		tx_valid <= 1'h1;
		tx_block <= 1'h1;
		{tx_last, tx_resp, tx_parity_err} <= f1;
		tx_data <= d1;
		@(posedge clk_sys);
		{tx_last, tx_resp, tx_parity_err} <= f2;
		tx_data <= d2;
		#1 tx_chk(f1, d1);
		n = 0;
		while (tx_ready !== 1'h1 && n < 9) begin
			@(posedge clk_sys);
			#1 n++;
		end
		@(posedge clk_sys);
		tx_valid <= 1'h0;
		#1 tx_chk(f2, d2);
	endtask
	task automatic rx_run(input int n, k, input logic e, b, nc, r,
		input int eb, el);
		#1 be_cnt = 0;
		li_cnt = 0;
		rv_cnt = 0;
		ls_cnt = 0;
		for (int i = 0; i < n; i++)
			agent_u.send(i == n - 1, r, e && i == k, nc, b && i == k,
				32'h1234_5600 + i);
		agent_u.idle();
		repeat (12) @(posedge clk_sys);
		chk(rv_cnt, n);
		chk(ls_cnt, 1);
		chk(rx_word, {1'h1, r, 32'h1234_5600 + n - 1});
		chk(be_cnt, eb);
		chk(li_cnt, el);
	endtask

	// ========
	// Scenarios
	task automatic t_regs();
		logic [31:0] v;
		rd(SDIE_MODE_ADDR, v);
		chk(v, 32'h000F_FFF0);
		for (int m = 0; m < 4; m++) begin
			wr(SDIE_MODE_ADDR, 32'hFFFF_FFF0 | (m << 1));
			rd(SDIE_MODE_ADDR, v);
			chk(v, 32'h000F_FFF0 | (m << 1));
			chk(write_mode, m[1:0]);
		end
		wr(36'hF_FF10_0008, 32'h0);
		rd(36'hF_FF10_0008, v);
		chk(v, 32'h0);
		rd(SDIE_MODE_ADDR, v);
		chk(v, 32'h000F_FFF6);
	endtask
	task automatic t_tx();
		int n;
		wr(SDIE_MODE_ADDR, 32'hFFFF_FFF0);
		tx_pair(3'h2, 3'h5, 32'hA5A5_0001, 32'h5A5A_0002, n);
		chk(n, 0);
		wr(SDIE_MODE_ADDR, 32'hFFFF_FFF1);
		tx_pair(3'h2, 3'h6, 32'h0F0F_0003, 32'hF0F0_0004, n);
		chk(n, 2);
		wr(SDIE_MODE_ADDR, 32'hFFFF_FFF0);
	endtask
	task automatic t_addr();
		logic [35:0] e;
		for (int s = 0; s < 5; s++) begin
			@(posedge clk_sys);
			req_valid <= 1'h1;
			req_addr <= 36'h9_8765_4323;
			req_size <= s[2:0];
			@(posedge clk_sys);
			req_valid <= 1'h0;
			e = 36'h9_8765_4323;
			if (s == 1)
				e[0] = 1'h0;
			if (s > 2)
				e[1:0] = 2'h0;
			#1 chk({addr_valid, addr_out}, {1'h1, e});
		end
	endtask
	task automatic t_tmo();
		logic [31:0] v;
		@(posedge clk_sys);
		protocol_select_pin <= 1'h0;
		repeat (4) @(posedge clk_sys);
		#1 be_cnt = 0;
		@(posedge clk_sys);
		read_issue <= 1'h1;
		@(posedge clk_sys);
		read_issue <= 1'h0;
		rd(SDIE_STAT_ADDR, v);
		chk(v, 32'h0000_0003);
		repeat (TMO + 4) @(posedge clk_sys);
		chk(be_cnt, 1);
		rd(SDIE_STAT_ADDR, v);
		chk(v, 32'h0000_0002);
		@(posedge clk_sys);
		protocol_select_pin <= 1'h1;
	endtask

	task automatic report_and_stop();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		repeat (12) @(posedge clk_sys);
		rst <= 1'h0;
		t_regs();
		t_tx();
		t_addr();
		rx_run(8, 3, 1'h1, 1'h0, 1'h0, 1'h1, 1, 1);
		rx_run(8, 7, 1'h0, 1'h1, 1'h0, 1'h1, 1, 1);
		rx_run(1, 0, 1'h0, 1'h1, 1'h1, 1'h1, 0, 0);
		rx_run(1, 0, 1'h1, 1'h0, 1'h0, 1'h0, 0, 0);
		rx_run(8, 9, 1'h0, 1'h0, 1'h0, 1'h1, 0, 0);
		t_tmo();
		report_and_stop();
	end
endmodule
